// *** core/sample_timing_core.sv ***
// Sample timing, converter capture, word reordering FIFO and serial output to the filter.
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic full, empty, push, pop;
  always_comb begin
    empty = (wr_q == rd_q);
    full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    in_ready_o = !full;
    out_valid_o = !empty;
    out_data_o = mem_q[rd_q[AW-1:0]];
    push = in_valid_i && !full;
    pop = out_ready_i && !empty;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q[AW-1:0]] = in_data_i;
      wr_d = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    mem_q <= mem_d;
  end
endmodule

// Operation
// - Each start pulse in the idle state raises sample hold and launches the variable-rate conversion clock.
// - Input shifter samples converter bits on the same conversion clock it issues.
// - Captured word is loaded bit-reversed, then shifted out LSB first at constant rate.
// - Every timing clock is divided down from the single reference clock.
// - Sample hold and conversion repeat at about 100 kHz, independent of trigger.
// - Programmable divide-by-N plus counter captured on trigger for phase relations.
// - Noise clock is divide-by-N output divided by seven; the divide-by-N output also feeds impulse.
// - Impulse output rate is the frequency width setting divided by 8192.
module sample_timing_core #(
  parameter int unsigned WORD_W = 12,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic conv_data_i,
  input wire logic [7:0] conv_half_i,
  input wire logic [15:0] divide_ratio_i,
  input wire logic trigger_i,
  input wire logic filt_timing_i,
  output logic sample_hold_o,
  output logic conv_clk_o,
  output logic ser_data_o,
  output logic ser_clk_o,
  output logic ser_frame_o,
  output logic noise_sequence_clk_o,
  output logic noise_sequence_start_o,
  output logic impulse_o,
  output sample_timing_pkg::phase_capture_t phase_o
);
  function automatic logic [WORD_W-1:0] reverse_bits(input logic [WORD_W-1:0] w);
    return {<<{w}};
  endfunction
  localparam logic [7:0] BIT_LAST = 8'(WORD_W - 1);
  // Pin inputs pass two flip-flops before use.
  logic data_m_q, data_s_q, trig_m_q, trig_s_q, trig_p_q, filt_m_q, filt_s_q, filt_p_q;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      {data_m_q, data_s_q, trig_m_q, trig_s_q, trig_p_q, filt_m_q, filt_s_q, filt_p_q} <= 8'h00;
    end else begin
      data_m_q <= conv_data_i;
      data_s_q <= data_m_q;
      trig_m_q <= trigger_i;
      trig_s_q <= trig_m_q;
      trig_p_q <= trig_s_q;
      filt_m_q <= filt_timing_i;
      filt_s_q <= filt_m_q;
      filt_p_q <= filt_s_q;
    end
  end

  // Conversion sequencing and input capture.
  sample_timing_pkg::conv_state_t cv_q, cv_d;
  logic [15:0] smp_q, smp_d;
  logic [7:0] cph_q, cph_d, cbit_q, cbit_d;
  logic cclk_q, cclk_d, hold_q, hold_d, start;
  logic [WORD_W-1:0] in_sr_q, in_sr_d;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;
  always_comb begin
    cv_d = cv_q;
    smp_d = smp_q + 16'h0001;
    cph_d = cph_q;
    cbit_d = cbit_q;
    cclk_d = cclk_q;
    hold_d = hold_q;
    in_sr_d = in_sr_q;
    fifo_in_valid = 1'b0;
    start = 1'b0;
    if (smp_q == sample_timing_pkg::SAMPLE_LAST) begin
      smp_d = 16'h0000;
      start = 1'b1;
    end
    case (cv_q)
      sample_timing_pkg::CV_IDLE: begin
        // A start that arrives while the previous word waits for FIFO room is dropped.
        if (start) begin
          cv_d = sample_timing_pkg::CV_HOLD;
          hold_d = 1'b1;
        end
      end
      sample_timing_pkg::CV_HOLD: begin
        cv_d = sample_timing_pkg::CV_SHIFT;
        cph_d = 8'h00;
        cbit_d = 8'h00;
      end
      sample_timing_pkg::CV_SHIFT: begin
        // Half period must be at least four cycles (conv_half_i of three) to cover the input synchroniser.
        if (cph_q >= conv_half_i) begin
          cph_d = 8'h00;
          cclk_d = !cclk_q;
          if (!cclk_q) begin
            in_sr_d = {data_s_q, in_sr_q[WORD_W-1:1]};
            cbit_d = cbit_q + 8'h01;
            if (cbit_q == BIT_LAST) begin
              cv_d = sample_timing_pkg::CV_PUSH;
              cclk_d = 1'b0;
              hold_d = 1'b0;
            end
          end
        end else begin
          cph_d = cph_q + 8'h01;
        end
      end
      sample_timing_pkg::CV_PUSH: begin
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          cv_d = sample_timing_pkg::CV_IDLE;
        end
      end
      default: begin
        cv_d = sample_timing_pkg::CV_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cv_q <= sample_timing_pkg::CV_IDLE;
      smp_q <= 16'h0000;
      cph_q <= 8'h00;
      cbit_q <= 8'h00;
      cclk_q <= 1'b0;
      hold_q <= 1'b0;
      in_sr_q <= '0;
    end else begin
      cv_q <= cv_d;
      smp_q <= smp_d;
      cph_q <= cph_d;
      cbit_q <= cbit_d;
      cclk_q <= cclk_d;
      hold_q <= hold_d;
      in_sr_q <= in_sr_d;
    end
  end

  word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(reverse_bits(in_sr_q)),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // Constant-rate serial output, LSB first.
  logic busy_q, busy_d, sclk_q, sclk_d, sdat_q, sdat_d;
  logic [WORD_W-1:0] out_sr_q, out_sr_d;
  logic [7:0] oph_q, oph_d, obit_q, obit_d;

  always_comb begin
    busy_d = busy_q;
    sclk_d = sclk_q;
    out_sr_d = out_sr_q;
    oph_d = oph_q;
    obit_d = obit_q;
    fifo_out_ready = !busy_q;
    if (!busy_q) begin
      if (fifo_out_valid) begin
        busy_d = 1'b1;
        out_sr_d = fifo_out_data;
        oph_d = 8'h00;
        obit_d = 8'h00;
      end
    end else if (oph_q == sample_timing_pkg::OUT_HALF_LAST) begin
      oph_d = 8'h00;
      sclk_d = !sclk_q;
      if (sclk_q) begin
        out_sr_d = {1'b0, out_sr_q[WORD_W-1:1]};
        obit_d = obit_q + 8'h01;
        if (obit_q == BIT_LAST) begin
          busy_d = 1'b0;
        end
      end
    end else begin
      oph_d = oph_q + 8'h01;
    end
    sdat_d = busy_d ? out_sr_d[0] : 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'b0;
      sclk_q <= 1'b0;
      sdat_q <= 1'b0;
      out_sr_q <= '0;
      oph_q <= 8'h00;
      obit_q <= 8'h00;
    end else begin
      busy_q <= busy_d;
      sclk_q <= sclk_d;
      sdat_q <= sdat_d;
      out_sr_q <= out_sr_d;
      oph_q <= oph_d;
      obit_q <= obit_d;
    end
  end

  // Divide-by-N, noise clock, impulse and trigger phase counters.
  logic [15:0] divn_q, divn_d;
  logic [2:0] noise_q, noise_d;
  logic [12:0] imp_q, imp_d;
  logic [15:0] eff_q, eff_d, dly_q, dly_d;
  logic divn_tick, ntick_q, ntick_d, nstart_q, nstart_d, started_q, started_d, imp_o_q, imp_o_d;
  sample_timing_pkg::phase_capture_t phase_q, phase_d;

  always_comb begin
    divn_d = divn_q + 16'h0001;
    divn_tick = 1'b0;
    // A ratio of zero or one yields a tick every cycle.
    if (divn_q + 16'h0001 >= divide_ratio_i) begin
      divn_d = 16'h0000;
      divn_tick = 1'b1;
    end
    noise_d = noise_q;
    ntick_d = 1'b0;
    imp_d = imp_q;
    imp_o_d = 1'b0;
    started_d = started_q;
    nstart_d = 1'b0;
    if (divn_tick) begin
      if (noise_q == sample_timing_pkg::NOISE_LAST) begin
        noise_d = 3'h0;
        ntick_d = 1'b1;
        started_d = 1'b1;
        nstart_d = !started_q;
      end else begin
        noise_d = noise_q + 3'h1;
      end
      if (started_q) begin
        imp_d = imp_q + 13'h0001;
        imp_o_d = (imp_q == sample_timing_pkg::IMPULSE_LAST);
      end
    end
    eff_d = divn_tick ? eff_q + 16'h0001 : eff_q;
    dly_d = start ? dly_q + 16'h0001 : dly_q;
    phase_d = phase_q;
    if (trig_s_q && !trig_p_q) begin
      phase_d.trig_count = eff_q;
      dly_d = sample_timing_pkg::CNT_RESET;
    end
    if (filt_s_q && !filt_p_q) begin
      phase_d.trig_delay = dly_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      divn_q <= 16'h0000;
      noise_q <= 3'h0;
      imp_q <= 13'h0000;
      ntick_q <= 1'b0;
      nstart_q <= 1'b0;
      started_q <= 1'b0;
      imp_o_q <= 1'b0;
      eff_q <= sample_timing_pkg::CNT_RESET;
      dly_q <= sample_timing_pkg::CNT_RESET;
      phase_q <= '0;
    end else begin
      divn_q <= divn_d;
      noise_q <= noise_d;
      imp_q <= imp_d;
      ntick_q <= ntick_d;
      nstart_q <= nstart_d;
      started_q <= started_d;
      imp_o_q <= imp_o_d;
      eff_q <= eff_d;
      dly_q <= dly_d;
      phase_q <= phase_d;
    end
  end
  assign sample_hold_o = hold_q;
  assign conv_clk_o = cclk_q;
  assign ser_data_o = sdat_q;
  assign ser_clk_o = sclk_q;
  assign ser_frame_o = busy_q;
  assign noise_sequence_clk_o = ntick_q;
  assign noise_sequence_start_o = nstart_q;
  assign impulse_o = imp_o_q;
  assign phase_o = phase_q;
endmodule
`default_nettype wire

// *** shared/sample_timing_pkg.sv ***
// Shared constants and types for the sample timing and data interface.
package sample_timing_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SAMPLE_RATE_HZ = 100_000;
  localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
  localparam logic [15:0] SAMPLE_LAST = 16'(SAMPLE_CYCLES - 1);
  localparam logic [2:0] NOISE_LAST = 3'h6;
  localparam logic [12:0] IMPULSE_LAST = 13'h1fff;
  localparam logic [7:0] OUT_HALF_LAST = 8'h03;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_HOLD = 2'b01,
    CV_SHIFT = 2'b10,
    CV_PUSH = 2'b11
  } conv_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] trig_count;
    logic [CNT_W-1:0] trig_delay;
  } phase_capture_t;
endpackage

// *** verif/sample_timing_checker.sv ***
// Port-level assertion checker for the sample timing core.
`timescale 1ns/100ps
`default_nettype none
module sample_timing_checker #(
  parameter int unsigned WORD_W = 12
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] divide_ratio_i,
  input wire logic sample_hold_o,
  input wire logic conv_clk_o,
  input wire logic ser_data_o,
  input wire logic ser_clk_o,
  input wire logic ser_frame_o,
  input wire logic noise_sequence_clk_o,
  input wire logic noise_sequence_start_o,
  input wire logic impulse_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [15:0] fr_q;
  // Frame length is counted here because it is too long for a repetition.
  always_ff @(posedge sys_clk_i) fr_q <= ser_frame_o ? fr_q + 16'h0001 : 16'h0000;
  sequence noise_gap;
    !noise_sequence_clk_o [*6] ##1 noise_sequence_clk_o;
  endsequence
  sequence half_high;
    ser_clk_o [*4] ##1 !ser_clk_o;
  endsequence
  chk_clk_in_hold: assert property ($rose(conv_clk_o) |-> $past(sample_hold_o))
    else $error("conversion clock rose outside hold");
  chk_hold_lead: assert property ($rose(sample_hold_o) |-> !conv_clk_o [*3])
    else $error("conversion clock started too early");
  chk_frame_len: assert property ($fell(ser_frame_o) |-> fr_q == 16'(8 * WORD_W))
    else $error("output frame length wrong");
  chk_idle_out: assert property (!ser_frame_o |-> !ser_data_o && !ser_clk_o)
    else $error("output active outside frame");
  chk_bit_edge: assert property (ser_frame_o && $past(ser_frame_o) && $changed(ser_data_o) |-> $fell(ser_clk_o))
    else $error("output bit changed off the falling edge");
  chk_out_rate: assert property ($rose(ser_clk_o) |-> half_high)
    else $error("output clock half period wrong");
  chk_noise_gap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i || divide_ratio_i > 16'h0001)
    noise_sequence_clk_o |=> noise_gap)
    else $error("noise clock period wrong");
  chk_noise_first: assert property (noise_sequence_start_o |-> noise_sequence_clk_o)
    else $error("noise start without noise clock");
  chk_impulse_one: assert property (impulse_o |=> !impulse_o)
    else $error("impulse longer than one cycle");
endmodule
bind sample_timing_core sample_timing_checker #(.WORD_W(WORD_W)) chk (.sys_clk_i, .rst_b_i, .divide_ratio_i,
  .sample_hold_o, .conv_clk_o, .ser_data_o, .ser_clk_o, .ser_frame_o, .noise_sequence_clk_o,
  .noise_sequence_start_o, .impulse_o);
`default_nettype wire

// *** verif/adc_model.sv ***
// Behavioural serial converter answering the hold and conversion clock.
`timescale 1ns/100ps
`default_nettype none
module adc_model (
  input wire logic sys_clk_i,
  input wire logic sample_hold_i,
  input wire logic conv_clk_i,
  input wire logic [11:0] word_i,
  output logic data_o
);
  logic [11:0] sh_q = 12'h000;
  logic hold_q = 1'b0;
  logic clk_q = 1'b0;
  logic dat_q = 1'b0;
  assign data_o = dat_q;
  // Bits move after a falling edge so they are settled before the next rise.
  always @(posedge sys_clk_i) begin
    hold_q <= sample_hold_i;
    clk_q <= conv_clk_i;
    if (sample_hold_i && !hold_q) begin
      sh_q <= word_i;
      dat_q <= word_i[11];
    end else if (clk_q && !conv_clk_i) begin
      sh_q <= {sh_q[10:0], 1'b0};
      dat_q <= sh_q[10];
    end else if (!sample_hold_i) begin
      dat_q <= ~dat_q;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_sample_timing_core.sv ***
// Self-checking bench for the sample timing core.
`timescale 1ns/100ps
`default_nettype none
module tb_sample_timing_core;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic trigger_i = 1'b0;
  logic filt_timing_i = 1'b0;
  logic [7:0] conv_half_i = 8'h03;
  logic [15:0] divide_ratio_i = 16'h0001;
  logic conv_data_i, sample_hold_o, conv_clk_o, ser_data_o, ser_clk_o, ser_frame_o;
  logic noise_sequence_clk_o, noise_sequence_start_o, impulse_o;
  sample_timing_pkg::phase_capture_t phase_o;
  logic [11:0] word_q = 12'h000;
  logic [11:0] rx_q = 12'h000;
  logic [15:0] lf = 16'h003f;
  logic ck_q = 1'b0;
  logic hd_q = 1'b0;
  logic [11:0] exp_q[$];
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int bitn = 0;
  int t_hold = 0;
  int t_imp = 0;
  int t0, n;
  int t_trig = 0;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  sample_timing_core dut (.sys_clk_i, .rst_b_i, .conv_data_i, .conv_half_i, .divide_ratio_i, .trigger_i,
    .filt_timing_i, .sample_hold_o, .conv_clk_o, .ser_data_o, .ser_clk_o, .ser_frame_o, .noise_sequence_clk_o,
    .noise_sequence_start_o, .impulse_o, .phase_o);
  adc_model cvt (.sys_clk_i, .sample_hold_i(sample_hold_o), .conv_clk_i(conv_clk_o), .word_i(word_q),
    .data_o(conv_data_i));
  // Blocking cycle count keeps time stamps free of scheduling order.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (!ser_frame_o) bitn = 0;
    else if (ser_clk_o && !ck_q) begin
      rx_q[bitn] = ser_data_o;
      bitn++;
      if (bitn == 12) check({4'h0, rx_q}, {4'h0, exp_q.pop_front()});
    end
    if (sample_hold_o && !hd_q) begin
      exp_q.push_back(word_q);
      if (t_hold != 0) check(16'(cyc - t_hold), 16'(sample_timing_pkg::SAMPLE_CYCLES));
      t_hold = cyc;
      word_q <= lf[11:0];
      lf <= lfsr(lf);
    end
    if (impulse_o && divide_ratio_i == 16'h0001) begin
      if (t_imp != 0) check(16'(cyc - t_imp), {3'h0, sample_timing_pkg::IMPULSE_LAST} + 16'h0001);
      t_imp = cyc;
    end
    ck_q = ser_clk_o;
    hd_q = sample_hold_o;
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    conv_half_i <= 8'h03 + {6'h00, lf[1:0]};
    repeat (8) @(posedge sample_hold_o);
    // Trigger just after a start, far from the next one, so the count is exact.
    trigger_i <= 1'b1;
    t_trig = cyc;
    repeat (3) @(posedge sample_hold_o);
    repeat (10) @(posedge sys_clk_i);
    filt_timing_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    check(phase_o.trig_delay, 16'h0003);
    // At ratio one a tick comes every cycle; synchroniser and edge stages delay the capture.
    check(phase_o.trig_count, 16'(t_trig - 1));
    n = 2 + int'(lf[2:0]);
    divide_ratio_i <= 16'(n);
    repeat (2) @(posedge noise_sequence_clk_o);
    t0 = cyc;
    @(posedge noise_sequence_clk_o);
    check(16'(cyc - t0), 16'(7 * n));
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
